// File: hw/bridge_punch_pkg.sv
// Constants, types and helpers shared by the punch-through status and mapping table block
`default_nettype none
package bridge_punch_pkg;
  // Configuration byte offsets
  localparam logic [11:0] PUNCH_SETUP_OFS = 12'h0a0;
  localparam logic [11:0] PUNCH_PAYLOAD_OFS = 12'h0a4;
  localparam logic [11:0] PUNCH_STATUS_OFS = 12'h0a8;
  localparam logic [11:0] MAP_POINTER_OFS = 12'h0ac;
  localparam logic [11:0] MAP_WINDOW_OFS = 12'h0b0;
  // Status field positions
  localparam int BUSY_BIT = 0;
  localparam int DONE_BIT = 1;
  localparam int CODE_LSB = 2;
  localparam int CODE_MSB = 4;
  localparam int ABORTED_BIT = 5;
  localparam int CAPABLE_BIT = 31;
  // Setup register: read_write_select position and writable bits
  localparam int READ_WRITE_SELECT_BIT = 31;
  localparam logic [31:0] SETUP_MASK = 32'hcfff_fffc;
  // Pointer field
  localparam int PTR_LSB = 2;
  localparam int PTR_MSB = 5;
  localparam int MAP_ENTRIES = 16;
  // Entry fields: valid 0, target_fn_number 18:16, target_slot_number 23:19, bus 31:24
  localparam int ENTRY_VALID_BIT = 0;
  localparam logic [31:0] ENTRY_MASK = 32'hffff_0001;
  localparam logic [3:0] BE_FULL = 4'hf;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Completion codes
  typedef enum logic [2:0] {
    CPL_SC = 3'h0,
    CPL_UR = 3'h1,
    CPL_CRS = 3'h2,
    CPL_CA = 3'h3,
    CPL_RA = 3'h4
  } cpl_code_t;

  // Punch-through engine
  typedef enum logic [0:0] {
    PT_IDLE = 1'b0,
    PT_BUSY = 1'b1
  } punch_state_t;

  // Configuration access from the requester
  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  // Transaction launched on the far side
  typedef struct packed {
    logic is_write;
    logic [31:0] setup;
    logic [3:0] be;
    logic [31:0] data;
  } punch_launch_t;

  // Dword offset match
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
    reg_hit = (addr[11:2] == ofs[11:2]);
  endfunction

  // Byte enables widened to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction
endpackage
`default_nettype wire

// File: hw/map_entry_table.sv
// Sixteen-entry requester mapping table with sticky storage
`default_nettype none
module map_entry_table
  import bridge_punch_pkg::*;
(
  // Clock and sticky reset
  input wire logic clock_i,
  input wire logic sticky_resetn_i,
  // Access port
  input wire logic [3:0] index_i,
  input wire logic we_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o
);
  logic [31:0] entry_q [MAP_ENTRIES];

  // One register per entry; only the sticky reset clears them
  for (genvar g = 0; g < MAP_ENTRIES; g++) begin : g_entry
    always_ff @(posedge clock_i or negedge sticky_resetn_i) begin
      if (!sticky_resetn_i) begin
        entry_q[g] <= WORD_ZERO;
      end else if (we_i && (index_i == 4'(g))) begin
        entry_q[g] <= wdata_i & ENTRY_MASK;
      end
    end
  end

  // Combinational read; caller registers it
  assign rdata_o = entry_q[index_i];
endmodule
`default_nettype wire

// File: hw/bridge_punch_status_and_map_table.sv
// Punch-through setup, payload and status registers with mapping table access port
`default_nettype none
module bridge_punch_status_and_map_table
  import bridge_punch_pkg::*;
(
  // Clock and resets
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic sticky_resetn_i,
  // Capability strap pin
  input wire logic punch_capable_i,
  // Configuration register access
  input wire logic cfg_valid_i,
  input wire cfg_req_t cfg_req_i,
  output logic cfg_ack_o,
  output logic cfg_ur_o,
  output logic [31:0] cfg_rdata_o,
  // Far-side transaction launch
  output logic launch_valid_o,
  output punch_launch_t launch_o,
  output logic abort_o,
  // Far-side completion
  input wire logic cpl_valid_i,
  input wire logic [2:0] cpl_code_i,
  input wire logic [31:0] cpl_data_i
);
  logic cap_meta_q, cap_q;
  punch_state_t state_q, state_d;
  logic done_q;
  logic [2:0] code_q;
  logic aborted_q;
  logic [31:0] setup_q, payload_q;
  logic [3:0] ptr_q;
  logic ack_q, ur_q, launch_valid_q, abort_q;
  logic [31:0] rdata_q;
  punch_launch_t launch_q;
  logic [31:0] tbl_rdata;

  // Access decode
  wire logic busy = (state_q == PT_BUSY);
  wire logic wr = cfg_valid_i & cfg_req_i.we;
  wire logic rd = cfg_valid_i & ~cfg_req_i.we;
  wire logic [31:0] bemask = lane_mask(cfg_req_i.be);
  wire logic hit_setup = reg_hit(cfg_req_i.addr, PUNCH_SETUP_OFS);
  wire logic hit_payload = reg_hit(cfg_req_i.addr, PUNCH_PAYLOAD_OFS);
  wire logic hit_status = reg_hit(cfg_req_i.addr, PUNCH_STATUS_OFS);
  wire logic hit_ptr = reg_hit(cfg_req_i.addr, MAP_POINTER_OFS);
  wire logic hit_window = reg_hit(cfg_req_i.addr, MAP_WINDOW_OFS);
  wire logic partial_window = cfg_valid_i & hit_window & (cfg_req_i.be != BE_FULL);
  wire logic op_write = setup_q[READ_WRITE_SELECT_BIT];

  // Engine events; a payload write while busy is dropped
  wire logic launch = wr & hit_payload & cap_q & ~busy;
  wire logic cpl = cpl_valid_i & busy;
  wire logic done_w1c = wr & hit_status & cfg_req_i.be[0] & cfg_req_i.wdata[DONE_BIT] & cap_q;
  // Completion in the same cycle beats the abort request
  wire logic abort = done_w1c & busy & ~cpl_valid_i;
  wire logic tbl_we = wr & hit_window & (cfg_req_i.be == BE_FULL);

  // Register images; status, setup and payload read zero when not capable, pointer and window do not
  wire logic [31:0] status_word = cap_q ?
    {1'b1, 25'h0, aborted_q, code_q, done_q, busy} : WORD_ZERO;
  wire logic [31:0] ptr_word = {26'h0, ptr_q, 2'h0};
  wire logic [31:0] setup_word = cap_q ? setup_q : WORD_ZERO;
  wire logic [31:0] payload_word = cap_q ? payload_q : WORD_ZERO;
  wire logic [31:0] rd_word = hit_status ? status_word :
    hit_ptr ? ptr_word :
    hit_window ? tbl_rdata :
    hit_setup ? setup_word :
    hit_payload ? payload_word : WORD_ZERO;

  // State transitions
  always_comb begin
    state_d = state_q;
    case (state_q)
      PT_IDLE: begin
        if (launch) state_d = PT_BUSY;
      end
      PT_BUSY: begin
        if (cpl || abort) state_d = PT_IDLE;
      end
      default: state_d = PT_IDLE;
    endcase
  end

  // Strap passes two flops; pin is asynchronous to the clock
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cap_meta_q <= 1'b1;
      cap_q <= 1'b1;
    end else begin
      cap_meta_q <= punch_capable_i;
      cap_q <= cap_meta_q;
    end
  end

  // Engine state and result code, cleared by resetn_i only, not by the sticky reset
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= PT_IDLE;
      code_q <= CPL_SC;
      aborted_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (cpl) begin
        code_q <= cpl_code_i;
        aborted_q <= (cpl_code_i == CPL_RA);
      end else if (abort) begin
        code_q <= CPL_RA;
        aborted_q <= 1'b1;
      end else if (launch) begin
        aborted_q <= 1'b0;
      end
    end
  end

  // Sticky registers survive the hot reset on resetn_i; only sticky_resetn_i clears them
  always_ff @(posedge clock_i or negedge sticky_resetn_i) begin
    if (!sticky_resetn_i) begin
      done_q <= 1'b0;
      ptr_q <= 4'h0;
      setup_q <= WORD_ZERO;
      payload_q <= WORD_ZERO;
    end else begin
      if (cpl) done_q <= 1'b1;
      else if (done_w1c || launch) done_q <= 1'b0;
      if (wr && hit_ptr && cfg_req_i.be[0]) ptr_q <= cfg_req_i.wdata[PTR_MSB:PTR_LSB];
      if (wr && hit_setup && cap_q) setup_q <= (setup_q & ~bemask) | (cfg_req_i.wdata & bemask & SETUP_MASK);
      if (launch && op_write) payload_q <= (payload_q & ~bemask) | (cfg_req_i.wdata & bemask);
      else if (cpl && !op_write) payload_q <= cpl_data_i;
    end
  end

  // Answer and launch outputs, one cycle after the request
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_q <= 1'b0;
      ur_q <= 1'b0;
      rdata_q <= WORD_ZERO;
      launch_valid_q <= 1'b0;
      launch_q <= '0;
      abort_q <= 1'b0;
    end else begin
      ack_q <= cfg_valid_i;
      ur_q <= partial_window;
      rdata_q <= (rd && !partial_window) ? rd_word : WORD_ZERO;
      launch_valid_q <= launch;
      abort_q <= abort;
      if (launch) launch_q <= '{is_write: op_write, setup: setup_q, be: cfg_req_i.be, data: cfg_req_i.wdata};
    end
  end

  assign cfg_ack_o = ack_q;
  assign cfg_ur_o = ur_q;
  assign cfg_rdata_o = rdata_q;
  assign launch_valid_o = launch_valid_q;
  assign launch_o = launch_q;
  assign abort_o = abort_q;

  // Mapping table storage
  map_entry_table u_table (
    .clock_i(clock_i),
    .sticky_resetn_i(sticky_resetn_i),
    .index_i(ptr_q),
    .we_i(tbl_we),
    .wdata_i(cfg_req_i.wdata),
    .rdata_o(tbl_rdata)
  );

  // Checks on the engine and the register answers
  // The pointer is compared as it stood at the request, since a pointer write may follow back to back
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i || !sticky_resetn_i);

  property p_launch_busy;
    launch |=> busy && status_word[BUSY_BIT] && launch_valid_o;
  endproperty
  a_launch_busy: assert property (p_launch_busy) else $error("busy not set after launch");

  property p_cpl_done;
    cpl |=> done_q && !busy && (code_q == $past(cpl_code_i));
  endproperty
  a_cpl_done: assert property (p_cpl_done) else $error("completion not recorded");

  property p_inflight_notdone;
    busy |-> !done_q;
  endproperty
  a_inflight_notdone: assert property (p_inflight_notdone) else $error("done set while in flight");

  property p_w1c_clear;
    (done_w1c && !cpl) |=> !done_q ##0 !busy;
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("done clear or abort failed");

  property p_abort_code;
    abort |=> abort_o && (code_q == CPL_RA) && aborted_q && !busy;
  endproperty
  a_abort_code: assert property (p_abort_code) else $error("abort not reported");

  property p_aborted_hold;
    (aborted_q && !launch) |=> aborted_q;
  endproperty
  a_aborted_hold: assert property (p_aborted_hold) else $error("aborted flag dropped early");

  property p_incapable_zero;
    (rd && hit_status && !cap_q) |=> cfg_ack_o && (cfg_rdata_o == WORD_ZERO);
  endproperty
  a_incapable_zero: assert property (p_incapable_zero) else $error("status not zero when incapable");

  property p_ptr_read;
    (rd && hit_ptr) |=> (cfg_rdata_o[31:6] == 26'h0) && (cfg_rdata_o[1:0] == 2'h0)
      && (cfg_rdata_o[PTR_MSB:PTR_LSB] == $past(ptr_q));
  endproperty
  a_ptr_read: assert property (p_ptr_read) else $error("pointer readback wrong");

  property p_window_read;
    (rd && hit_window && !partial_window) |=> cfg_rdata_o == $past(tbl_rdata);
  endproperty
  a_window_read: assert property (p_window_read) else $error("window read mismatch");

  property p_partial_ur;
    partial_window |=> cfg_ur_o && cfg_ack_o;
  endproperty
  a_partial_ur: assert property (p_partial_ur) else $error("partial access not refused");

  cover property (launch ##[1:20] cpl);
  cover property (busy && abort);
  cover property (tbl_we ##1 (rd && hit_window));
endmodule
`default_nettype wire

// File: testbench/far_completer.sv
// Far-side configuration completer answering launched punch-through transactions
`default_nettype none
module far_completer
  import bridge_punch_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Launch and abort from the block
  input wire logic launch_valid_i,
  input wire punch_launch_t launch_i,
  input wire logic abort_i,
  // Answer shaping; a zero delay never answers
  input wire logic [7:0] delay_i,
  input wire logic [2:0] code_i,
  // Completion back to the block
  output logic cpl_valid_o,
  output logic [2:0] cpl_code_o,
  output logic [31:0] cpl_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wait_q;
  logic [31:0] result;
  // Read result derived from the target setup, so the bench can predict it
  assign result = launch_i.setup ^ 32'h5a5a_5a5a;
  // Outside the pulse the data lines show the inverse and the code lines 7, never a stale copy
  assign cpl_data_o = cpl_valid_o ? result : ~result;
  assign cpl_code_o = cpl_valid_o ? code_i : 3'h7;
  // One outstanding transaction; an abort forgets it
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_q <= 8'h00;
      cpl_valid_o <= 1'b0;
    end else begin
      cpl_valid_o <= (wait_q == 8'h01) && !abort_i;
      if (launch_valid_i) begin
        wait_q <= delay_i;
      end else if (abort_i) begin
        wait_q <= 8'h00;
      end else if (wait_q != 8'h00) begin
        wait_q <= wait_q - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/test_bridge_punch_status_and_map_table.sv
// Self-checking bench for the punch-through status and mapping table block
`default_nettype none
module test_bridge_punch_status_and_map_table
  import bridge_punch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic sticky_resetn_i = 1'b0;
  logic cap = 1'b1;
  logic cfg_valid = 1'b0;
  cfg_req_t cfg_req = '0;
  logic [7:0] dly = 8'h06;
  logic [2:0] code = 3'h0;
  logic ack, ur, lv, ab, cpl_valid;
  logic [31:0] rdata, cpl_data;
  logic [2:0] cpl_code;
  punch_launch_t lo, got_lo;
  logic [31:0] got_rd;
  logic got_ur, got_lv, got_ab;
  int num_errors = 0;
  int total_checks = 0;
  // 20 MHz clock
  always #25 clock_i = ~clock_i;
  bridge_punch_status_and_map_table u_bridge_punch_status_and_map_table (
    .clock_i(clock_i), .resetn_i(resetn_i), .sticky_resetn_i(sticky_resetn_i), .punch_capable_i(cap),
    .cfg_valid_i(cfg_valid), .cfg_req_i(cfg_req), .cfg_ack_o(ack), .cfg_ur_o(ur), .cfg_rdata_o(rdata),
    .launch_valid_o(lv), .launch_o(lo), .abort_o(ab),
    .cpl_valid_i(cpl_valid), .cpl_code_i(cpl_code), .cpl_data_i(cpl_data));
  far_completer u_far_completer (
    .clock_i(clock_i), .resetn_i(resetn_i), .launch_valid_i(lv), .launch_i(lo), .abort_i(ab),
    .delay_i(dly), .code_i(code), .cpl_valid_o(cpl_valid), .cpl_code_o(cpl_code), .cpl_data_o(cpl_data));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One request, answer sampled one cycle later while it stands
  task automatic acc(input logic we, input logic [11:0] addr, input logic [3:0] be, input logic [31:0] wd);
    @(negedge clock_i);
    cfg_valid = 1'b1;
    cfg_req = '{we, addr, be, wd};
    @(negedge clock_i);
    cfg_valid = 1'b0;
    check({31'h0, ack}, 32'h1);
    got_rd = rdata;
    got_ur = ur;
    got_lv = lv;
    got_lo = lo;
    got_ab = ab;
  endtask
  task automatic wr(input logic [11:0] addr, input logic [3:0] be, input logic [31:0] wd);
    acc(1'b1, addr, be, wd);
  endtask
  task automatic rdchk(input logic [11:0] addr, input logic [31:0] mask, input logic [31:0] exp);
    acc(1'b0, addr, BE_FULL, WORD_ZERO);
    check(got_rd & mask, exp);
  endtask
  // Bounded poll for the completion flag
  task automatic wait_done();
    for (int n = 0; n < 40; n++) begin
      acc(1'b0, PUNCH_STATUS_OFS, BE_FULL, WORD_ZERO);
      if (got_rd[1] === 1'b1) return;
    end
    num_errors++;
    $display("MISMATCH at %0t: completion never seen", $time);
    close_out();
  endtask
  function automatic logic [31:0] ent(input int i);
    ent = 32'h9e37_79b9 * 32'(i + 1);
  endfunction
  initial begin
    repeat (20) @(negedge clock_i);
    resetn_i = 1'b1;
    sticky_resetn_i = 1'b1;
    rdchk(PUNCH_STATUS_OFS, 32'hffff_ffff, 32'h8000_0000);
    // Fill every entry with junk in the reserved bits, then read all back
    for (int i = 0; i < 16; i++) begin
      wr(MAP_POINTER_OFS, BE_FULL, 32'hffff_ffc3 | 32'(i << 2));
      rdchk(MAP_POINTER_OFS, 32'hffff_ffff, 32'(i << 2));
      wr(MAP_WINDOW_OFS, BE_FULL, ent(i));
    end
    for (int i = 0; i < 16; i++) begin
      wr(MAP_POINTER_OFS, BE_FULL, 32'(i << 2));
      rdchk(MAP_WINDOW_OFS, 32'hffff_ffff, ent(i) & 32'hffff_0001);
    end
    // Partial accesses refused, entry untouched; unmapped reads zero
    wr(MAP_WINDOW_OFS, 4'h3, WORD_ZERO);
    check({31'h0, got_ur}, 32'h1);
    acc(1'b0, MAP_WINDOW_OFS, 4'h1, WORD_ZERO);
    check({got_rd[30:0], got_ur}, 32'h1);
    rdchk(MAP_WINDOW_OFS, 32'hffff_ffff, ent(15) & 32'hffff_0001);
    rdchk(12'h0b4, 32'hffff_ffff, WORD_ZERO);
    // Read operations through every completion code
    for (int c = 0; c < 5; c++) begin
      code = 3'(c);
      wr(PUNCH_SETUP_OFS, BE_FULL, 32'h0012_3400 + 32'(c << 2));
      wr(PUNCH_PAYLOAD_OFS, 4'h5, 32'hffff_ffff);
      check({26'h0, got_lv, got_lo.is_write, got_lo.be}, 32'h25);
      rdchk(PUNCH_STATUS_OFS, 32'hffff_ffe3, 32'h8000_0001);
      wait_done();
      rdchk(PUNCH_STATUS_OFS, 32'hffff_ffff, 32'h8000_0002 | 32'(c << 2) | (c == 4 ? 32'h20 : 32'h0));
      rdchk(PUNCH_PAYLOAD_OFS, 32'hffff_ffff, (32'h0012_3400 + 32'(c << 2)) ^ 32'h5a5a_5a5a);
      wr(PUNCH_STATUS_OFS, BE_FULL, 32'h0000_0002);
      rdchk(PUNCH_STATUS_OFS, 32'hffff_ffe3, c == 4 ? 32'h8000_0020 : 32'h8000_0000);
    end
    // Write operation that never completes, then aborted
    dly = 8'h00;
    wr(PUNCH_SETUP_OFS, BE_FULL, 32'h8000_0008);
    wr(PUNCH_PAYLOAD_OFS, BE_FULL, 32'hcafe_f00d);
    check(got_lo.data, 32'hcafe_f00d);
    check(got_lo.setup, 32'h8000_0008);
    check({31'h0, got_lo.is_write}, 32'h1);
    rdchk(PUNCH_STATUS_OFS, 32'hffff_ffe3, 32'h8000_0001);
    wr(PUNCH_PAYLOAD_OFS, BE_FULL, WORD_ZERO);
    check({31'h0, got_lv}, 32'h0);
    wr(PUNCH_STATUS_OFS, BE_FULL, 32'h0000_0002);
    check({31'h0, got_ab}, 32'h1);
    rdchk(PUNCH_STATUS_OFS, 32'hffff_ffff, 32'h8000_0030);
    // Payload keeps the launching write; the write while busy was dropped
    rdchk(PUNCH_PAYLOAD_OFS, 32'hffff_ffff, 32'hcafe_f00d);
    // Completion flag, pointer and table survive a hot reset
    dly = 8'h06;
    wr(PUNCH_PAYLOAD_OFS, BE_FULL, 32'h0000_0001);
    wait_done();
    resetn_i = 1'b0;
    repeat (3) @(negedge clock_i);
    resetn_i = 1'b1;
    rdchk(PUNCH_STATUS_OFS, 32'h0000_0003, 32'h0000_0002);
    rdchk(MAP_POINTER_OFS, 32'hffff_ffff, 32'h0000_003c);
    rdchk(MAP_WINDOW_OFS, 32'hffff_ffff, ent(15) & 32'hffff_0001);
    // Strap low: punch registers read zero and launch nothing
    cap = 1'b0;
    repeat (4) @(negedge clock_i);
    rdchk(PUNCH_STATUS_OFS, 32'hffff_ffff, WORD_ZERO);
    rdchk(PUNCH_SETUP_OFS, 32'hffff_ffff, WORD_ZERO);
    rdchk(PUNCH_PAYLOAD_OFS, 32'hffff_ffff, WORD_ZERO);
    wr(PUNCH_PAYLOAD_OFS, BE_FULL, 32'h0000_0001);
    check({31'h0, got_lv}, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
